// File: verilog/aid_params.svh
`ifndef AID_PARAMS_SVH
`define AID_PARAMS_SVH

// instruction field layout
`define AID_OPC_HI 15
`define AID_OPC_LO 8
`define AID_OPC_ADDLIT 8'h0F
`define AID_OPC6_HI 15
`define AID_OPC6_LO 10
`define AID_OPC6_ADDREG 6'h09
`define AID_DEST_BIT 9
`define AID_BANK_BIT 8
// access bank split: low half in bank 0, high half in the top bank
`define AID_ACCESS_SPLIT 8'h80
`define AID_ACCESS_HI_BANK 4'hF
`define AID_ACC_RESET 8'h00
`define AID_BANK_RESET 4'h0

`endif

// File: verilog/aid_pkg.sv
package aid_pkg;
	typedef enum logic [1:0] {
		AID_Q1,
		AID_Q2,
		AID_Q3,
		AID_Q4
	} aid_phase_t;

	typedef enum logic [1:0] {
		AID_OP_NONE,
		AID_OP_LIT,
		AID_OP_REG
	} aid_op_t;

	typedef struct packed {
		logic n;
		logic ov;
		logic c;
		logic dc;
		logic z;
	} aid_flags_t;
endpackage : aid_pkg

// File: verilog/aid_adder.sv
`timescale 1ns/1ps
// 8-bit adder with status; result and flags registered
module aid_adder #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] a_in,
	input wire logic [WIDTH-1:0] b_in,
	output logic [WIDTH-1:0] sum_out,
	output aid_pkg::aid_flags_t flags_out
);
	typedef struct packed {
		logic [WIDTH-1:0] sum;
		aid_pkg::aid_flags_t flags;
	} aid_add_state_t;

	aid_add_state_t st;
	aid_add_state_t next_st;
	logic [WIDTH:0] full;
	logic [4:0] low;

	always_comb begin
		next_st = st;
		full = {1'b0, a_in} + {1'b0, b_in};
		low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
		if (load_in) begin
			next_st.sum = full[WIDTH-1:0];
			next_st.flags.c = full[WIDTH];
			next_st.flags.dc = low[4];
			next_st.flags.n = full[WIDTH-1];
			next_st.flags.z = (full[WIDTH-1:0] == '0);
			// overflow: equal operand signs, result sign differs
			next_st.flags.ov = (a_in[WIDTH-1] == b_in[WIDTH-1]) &&
				(full[WIDTH-1] != a_in[WIDTH-1]);
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sum_out = st.sum;
	assign flags_out = st.flags;
endmodule : aid_adder

// File: verilog/aid_datapath.sv
`timescale 1ns/1ps
`include "aid_params.svh"
module aid_datapath #(
	parameter int DW = 8,
	parameter int BW = 4
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// instruction side, looked at only on the edge that ends Q1
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_in,
	input wire logic [BW-1:0] bank_select_pointer_in,
	// operand read data, sampled at the edge that ends Q2
	input wire logic [DW-1:0] mem_rdata_in,
	// every output below is a register
	output logic [1:0] phase_out,
	output logic busy_out,
	output logic [BW+DW-1:0] mem_addr_out,
	output logic mem_rd_out,
	output logic mem_wr_out,
	output logic [DW-1:0] mem_wdata_out,
	output logic [DW-1:0] acc_out,
	output logic [4:0] status_out,
	output logic done_out
);
	// data address: bank number above the register address
	localparam int AW = BW + DW;

	typedef struct packed {
		// sequencing
		aid_pkg::aid_phase_t phase;
		aid_pkg::aid_op_t op;
		// decoded instruction
		logic dest_reg;
		logic [DW-1:0] operand;
		// architectural state and memory strobes
		logic [DW-1:0] acc;
		logic [AW-1:0] addr;
		logic rd;
		logic wr;
		logic [DW-1:0] wdata;
		logic busy;
		logic done;
	} aid_state_t;

	// reset image: phase Q1, nothing in flight, accumulator at its reset value
	localparam aid_state_t RESET_ST = '{
		phase: aid_pkg::AID_Q1,
		op: aid_pkg::AID_OP_NONE,
		acc: DW'(`AID_ACC_RESET),
		default: '0
	};

	aid_state_t st;
	aid_state_t next_st;
	logic taken;
	logic add_load;
	logic [DW-1:0] sum;
	aid_pkg::aid_flags_t flags;

	// instruction field decoders

	// the literal opcode is a full byte, the register form only six bits
	function automatic logic is_add_lit(input logic [15:0] w);
		return w[`AID_OPC_HI:`AID_OPC_LO] == `AID_OPC_ADDLIT;
	endfunction : is_add_lit

	function automatic logic is_add_reg(input logic [15:0] w);
		return w[`AID_OPC6_HI:`AID_OPC6_LO] == `AID_OPC6_ADDREG;
	endfunction : is_add_reg

	// anything that is neither add runs its phases with no effect
	function automatic aid_pkg::aid_op_t decode_op(input logic [15:0] w);
		aid_pkg::aid_op_t op;
		op = aid_pkg::AID_OP_NONE;
		if (is_add_lit(w)) begin
			op = aid_pkg::AID_OP_LIT;
		end else if (is_add_reg(w)) begin
			op = aid_pkg::AID_OP_REG;
		end
		return op;
	endfunction : decode_op

	// literal and register address share the low byte of the word
	function automatic logic [DW-1:0] low_field(input logic [15:0] w);
		return w[DW-1:0];
	endfunction : low_field

	function automatic logic dest_is_reg(input logic [15:0] w);
		return w[`AID_DEST_BIT];
	endfunction : dest_is_reg

	function automatic logic uses_bank_ptr(input logic [15:0] w);
		return w[`AID_BANK_BIT];
	endfunction : uses_bank_ptr

	// access bank maps low addresses to bank 0, high addresses to the top bank;
	// the pointer is ignored there, so common registers need no bank switch
	function automatic logic [AW-1:0] resolve_addr(input logic [DW-1:0] f,
		input logic use_bank, input logic [BW-1:0] bank);
		logic [BW-1:0] b;
		b = '0;
		if (use_bank) begin
			b = bank;
		end else if (f >= DW'(`AID_ACCESS_SPLIT)) begin
			b = BW'(`AID_ACCESS_HI_BANK);
		end
		return {b, f};
	endfunction : resolve_addr

	// the phase sequence never stalls: every instruction takes one full pass
	function automatic aid_pkg::aid_phase_t next_phase(input aid_pkg::aid_phase_t p);
		aid_pkg::aid_phase_t n;
		n = aid_pkg::AID_Q1;
		unique case (p)
			aid_pkg::AID_Q1: n = aid_pkg::AID_Q2;
			aid_pkg::AID_Q2: n = aid_pkg::AID_Q3;
			aid_pkg::AID_Q3: n = aid_pkg::AID_Q4;
			aid_pkg::AID_Q4: n = aid_pkg::AID_Q1;
		endcase
		return n;
	endfunction : next_phase

	function automatic logic op_active(input aid_pkg::aid_op_t op);
		return op != aid_pkg::AID_OP_NONE;
	endfunction : op_active

	// operands: the accumulator and either the literal or the register value
	aid_adder #(.WIDTH(DW)) u_add (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.load_in(add_load),
		.a_in(st.acc),
		.b_in(st.operand),
		.sum_out(sum),
		.flags_out(flags)
	);

	// sum and status are captured at the Q3 edge so they stand through Q4;
	// a word that is no add leaves the flags untouched
	assign taken = instr_valid_in && (st.phase == aid_pkg::AID_Q1);
	assign add_load = (st.phase == aid_pkg::AID_Q3) && op_active(st.op);

	// strobes and done are one-cycle pulses unless a phase raises them
	always_comb begin
		next_st = st;
		next_st.rd = 1'b0;
		next_st.wr = 1'b0;
		next_st.done = 1'b0;
		next_st.phase = next_phase(st.phase);
		unique case (st.phase)
			aid_pkg::AID_Q1: begin
				// fields are latched every pass; only op, busy and rd depend on valid
				next_st.op = taken ? decode_op(instr_in) : aid_pkg::AID_OP_NONE;
				next_st.dest_reg = dest_is_reg(instr_in);
				next_st.operand = low_field(instr_in);
				next_st.addr = resolve_addr(low_field(instr_in), uses_bank_ptr(instr_in),
					bank_select_pointer_in);
				next_st.busy = taken;
				next_st.rd = taken && (decode_op(instr_in) == aid_pkg::AID_OP_REG);
			end
			aid_pkg::AID_Q2: begin
				// the read pulse stood through Q2, so the register value is on the bus
				if (st.op == aid_pkg::AID_OP_REG) begin
					next_st.operand = mem_rdata_in;
				end
			end
			aid_pkg::AID_Q3: begin
				// the adder registers sum and status at this edge
			end
			aid_pkg::AID_Q4: begin
				next_st.busy = 1'b0;
				next_st.done = op_active(st.op);
				// a register write lands at the end of the next Q1, before the
				// next instruction reads in Q2, so back-to-back adds see fresh data
				unique case (st.op)
					aid_pkg::AID_OP_LIT: begin
						next_st.acc = sum;
					end
					aid_pkg::AID_OP_REG: begin
						if (st.dest_reg) begin
							next_st.wr = 1'b1;
							next_st.wdata = sum;
						end else begin
							next_st.acc = sum;
						end
					end
					aid_pkg::AID_OP_NONE: begin
						// unknown words: no write, no flags
					end
					default: begin
					end
				endcase
			end
		endcase
	end

	// one register for the whole state keeps the phase and its data in step
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	// status comes from the adder's own flops, so it too is a register output
	assign phase_out = st.phase;
	assign busy_out = st.busy;
	assign mem_addr_out = st.addr;
	assign mem_rd_out = st.rd;
	assign mem_wr_out = st.wr;
	assign mem_wdata_out = st.wdata;
	assign acc_out = st.acc;
	assign status_out = flags;
	assign done_out = st.done;
endmodule : aid_datapath

// File: tb/aid_datapath_asserts.sv
`timescale 1ns/1ps
module aid_chk (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_in,
	input wire logic [3:0] bank_select_pointer_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [1:0] phase_out,
	input wire logic [11:0] mem_addr_out,
	input wire logic mem_rd_out,
	input wire logic mem_wr_out,
	input wire logic [7:0] mem_wdata_out,
	input wire logic [7:0] acc_out,
	input wire logic [4:0] status_out,
	input wire logic done_out
);
	wire tk = phase_out == 2'h0 && instr_valid_in;
	wire lit = tk && instr_in[15:8] == 8'h0F;
	wire rg = tk && instr_in[15:10] == 6'h09;
	wire f7 = instr_in[7];
	wire [7:0] k = instr_in[7:0];
	wire [7:0] res = mem_wr_out ? mem_wdata_out : acc_out;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_lit_sum: assert property (lit |-> ##4 done_out && acc_out == 8'($past(acc_out, 4) + $past(k, 4)))
		else $error("literal sum wrong");
	a_lit_nowr: assert property (lit |-> ##1 !mem_wr_out [*4])
		else $error("literal add wrote memory");
	a_dest_acc: assert property (rg && !instr_in[9] |-> ##4 done_out && !mem_wr_out
		&& acc_out == 8'($past(acc_out, 4) + $past(mem_rdata_in, 3)))
		else $error("sum not in acc");
	a_dest_reg: assert property (rg && instr_in[9] |-> ##4 done_out && mem_wr_out
		&& mem_wdata_out == 8'($past(acc_out, 4) + $past(mem_rdata_in, 3)))
		else $error("sum not written back");
	a_access_bank: assert property (rg && !instr_in[8] |=> mem_rd_out
		&& mem_addr_out == {$past(f7) ? 4'hF : 4'h0, $past(k)})
		else $error("access bank address wrong");
	a_bank_ptr: assert property (rg && instr_in[8] |=> mem_rd_out
		&& mem_addr_out == {$past(bank_select_pointer_in), $past(k)})
		else $error("banked address wrong");
	a_rd_pulse: assert property ($rose(mem_rd_out) |-> phase_out == 2'h1 ##1 !mem_rd_out)
		else $error("read pulse wrong");
	a_phase_walk: assert property (phase_out == 2'h1 |=> phase_out == 2'h2 ##1 phase_out == 2'h3
		##1 phase_out == 2'h0)
		else $error("phase order wrong");
	a_zero_flag: assert property (done_out |-> status_out[0] == (res == 8'h00))
		else $error("zero flag wrong");
endmodule : aid_chk
bind aid_datapath aid_chk u_chk (.*);

// File: tb/aid_mem_model.sv
`timescale 1ns/1ps
module aid_mem_model (
	input wire logic clk_in,
	input wire logic [11:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] m [4096];
	logic [7:0] last = 8'h00;
	// off-cycle data is inverted so a late sample cannot match by luck
	assign rdata_out = rd_in ? m[addr_in] : ~last;
	always @(posedge clk_in) begin
		if (rd_in) last <= m[addr_in];
		if (wr_in) m[addr_in] <= wdata_in;
	end
endmodule : aid_mem_model

// File: tb/aid_datapath_bench.sv
`timescale 1ns/1ps
module add_instruction_datapath_bench;
	logic clk = 0, nrst = 0, vld = 0;
	logic [15:0] ins = 16'h0000;
	logic [3:0] bsp = 4'h0;
	wire [7:0] rdata, wdata, acc;
	wire [11:0] addr;
	wire [1:0] ph;
	wire [4:0] st;
	wire rd, wr, done, busy;
	int num_errors = 0, tests_run = 0;
	aid_datapath uut (.core_clk_in(clk), .nrst_in(nrst), .instr_valid_in(vld), .instr_in(ins),
		.bank_select_pointer_in(bsp), .mem_rdata_in(rdata), .phase_out(ph), .busy_out(busy),
		.mem_addr_out(addr), .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdata),
		.acc_out(acc), .status_out(st), .done_out(done));
	aid_mem_model mem (.clk_in(clk), .addr_in(addr), .rd_in(rd), .wr_in(wr),
		.wdata_in(wdata), .rdata_out(rdata));
	initial begin
		forever #25 clk = ~clk;
	end
	task tally_and_finish;
		$display("tests %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task run(input logic [15:0] i);
		int n;
		n = 0;
		// a word is only taken at the edge that ends a Q1 phase
		while (ph !== 2'h0 && n < 8) begin
			@(posedge clk) #1;
			n++;
		end
		ins = i;
		vld = 1;
		@(posedge clk) #1;
		vld = 0;
		chk({7'h00, busy}, 8'h01);
		while (done !== 1'b1 && n < 16) begin
			@(posedge clk) #1;
			n++;
		end
		if (done !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t no done", $time);
			tally_and_finish;
		end
		chk({7'h00, busy}, 8'h00);
	endtask : run
	task t_lit;
		run(16'h0F15);
		chk(acc, 8'h15);
		run(16'h0FEB);
		chk(acc, 8'h00);
		chk({3'h0, st}, 8'h07);
		$display("t_lit end");
	endtask : t_lit
	task t_dest_acc;
		mem.m[12'hFC2] = 8'hC2;
		run(16'h0F17);
		run(16'h24C2);
		chk(acc, 8'hD9);
		chk({3'h0, st}, 8'h10);
		$display("t_dest_acc end");
	endtask : t_dest_acc
	task t_dest_reg;
		bsp = 4'h3;
		mem.m[12'h310] = 8'h05;
		mem.m[12'h010] = 8'h01;
		run(16'h2710);
		chk(wdata, 8'hDE);
		chk(acc, 8'hD9);
		// low access half must ignore the pointer
		run(16'h2410);
		chk(acc, 8'hDA);
		chk(mem.m[12'h310], 8'hDE);
		$display("t_dest_reg end");
	endtask : t_dest_reg
	initial begin
		repeat (4) @(posedge clk);
		#1 nrst = 1;
		t_lit;
		t_dest_acc;
		t_dest_reg;
		tally_and_finish;
	end
endmodule : add_instruction_datapath_bench
